// >>> logic/clear_window_select_axil_slave.sv
// AXI4-Lite slave: turns bus transfers into write pulses and read strobes.
// Assumes a master that keeps valid and payload until the handshake.
`timescale 1ns/100ps
module clear_window_select_axil_slave import clear_window_select_pkg::*; (
  input wire logic clk, // System clock
  input wire logic srst, // Sync reset
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic wr_en, // Register write pulse
  output clear_window_select_wreq_t wr_req, // Register write payload
  output logic rd_en, // Register read strobe
  input wire logic [31:0] rd_data // Data at araddr
);
  clear_window_select_axs_t s_r;
  clear_window_select_axs_t s_nxt;

  assign awready = s_r.aw_rdy;
  assign wready = s_r.w_rdy;
  assign arready = s_r.ar_rdy;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign wr_en = s_r.wr_en;
  assign wr_req = s_r.req;
  assign rd_en = arvalid && s_r.ar_rdy;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_en = 1'b0;
    if (awvalid && s_r.aw_rdy) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.req.addr = awaddr;
    end
    if (wvalid && s_r.w_rdy) begin
      s_nxt.w_have = 1'b1;
      s_nxt.req.data = wdata;
      s_nxt.req.strb = wstrb;
    end
    if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;
    // Both halves held: issue the write if the address is mapped, and its response
    if (s_r.aw_have && s_r.w_have) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.wr_en = clear_window_select_mapped(s_r.req.addr);
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = clear_window_select_mapped(s_r.req.addr) ? CLEAR_WINDOW_SELECT_RESP_OK : CLEAR_WINDOW_SELECT_RESP_ERR;
    end
    if (s_r.rvalid && rready)
      s_nxt.rvalid = 1'b0;
    if (rd_en) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data;
      s_nxt.rresp = clear_window_select_mapped(araddr) ? CLEAR_WINDOW_SELECT_RESP_OK : CLEAR_WINDOW_SELECT_RESP_ERR;
    end
    s_nxt.aw_rdy = !s_nxt.aw_have && !s_nxt.bvalid && !s_nxt.wr_en;
    s_nxt.w_rdy = !s_nxt.w_have && !s_nxt.bvalid && !s_nxt.wr_en;
    s_nxt.ar_rdy = !s_nxt.rvalid;
  end

  always_ff @(posedge clk) begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : clear_window_select_axil_slave

// >>> logic/clear_window_select_core.sv
// Windowed watchdog: 8-bit up counter, clear window, overflow action.
// Assumes an AXI4-Lite master and a chip reset controller that takes
// chip_rst_req, applies srst and runs warm-up with mode_hold high.
//
// Behaviour
// - Overflow with action select 1 raises a watchdog reset request.
// - The reset request resets the chip, then warm-up follows.
// - Clear code 0x4E zeroes the counter; counting then continues.
// - Disable code 0xB1 stops the watchdog only while enable is 0.
// - A clear in the overflow cycle wins; no overflow is detected.
// - Counter monitor reads return the present counter value.
// - Operating state flag is 1 while enabled, 0 while disabled.
// - Overflow interrupt request sets the overflow cause flag.
// - Out-of-window clear interrupt request sets the window flag.
// - Reading status clears both cause flags.
// - A cause set in the read cycle leaves that flag at 1.
// - Window 00 clears any time; else early clear interrupts, no clear.
// - Overflow with action 0 raises a non-maskable request, keeps counting.
// - Disabling through the disable code also zeroes the counter.
// - Counter pauses in stop, warm-up, idle or sleep, resumes after.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module clear_window_select_core import clear_window_select_pkg::*; #(
  parameter int BASE_DIV = 16
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic srst, // Sync reset, chip reset
  input wire logic mode_hold, // Stop, warm-up, idle or sleep
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic irq, // Maskable interrupt level
  output logic nmi_req, // Non-maskable request pulse
  output logic chip_rst_req // Chip reset request pulse
);
  clear_window_select_core_t c_r;
  clear_window_select_core_t c_nxt;
  logic wr_en;
  clear_window_select_wreq_t wr_req;
  logic rd_en;
  logic [31:0] rd_data;
  logic tick;
  logic wr_lo;
  logic code_wr;
  logic clr_try;
  logic clr_ok;
  logic clr_bad;
  logic dis_ok;
  logic ovf;
  logic sts_rd;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  clear_window_select_axil_slave u_bus (
    .clk(clk), .srst(srst),
    .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
    .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en), .wr_req(wr_req), .rd_en(rd_en), .rd_data(rd_data)
  );

  clear_window_select_tick_div #(.BASE_DIV(BASE_DIV)) u_div (
    .clk(clk), .srst(srst), .per(c_r.per), .tick(tick)
  );

  assign irq = c_r.irq;
  assign nmi_req = c_r.nmi;
  assign chip_rst_req = c_r.crst;

  // ****************************************************************
  // Clear window decode
  // ****************************************************************
  function automatic logic win_open(input logic [1:0] w,
                                    input logic [7:0] n);
    unique case (w)
      2'h0: return 1'b1;
      2'h1: return n[7];
      2'h2: return &n[7:6];
      2'h3: return &n[7:5];
    endcase
  endfunction : win_open

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rd_data = '0;
    unique case (s_axi_araddr)
      CLEAR_WINDOW_SELECT_CFG_OFS: rd_data[7:0] = {2'h0, c_r.per, c_r.win, c_r.act, c_r.en};
      CLEAR_WINDOW_SELECT_CNT_OFS: rd_data[7:0] = c_r.cnt;
      CLEAR_WINDOW_SELECT_STS_OFS: rd_data[7:0] = CLEAR_WINDOW_SELECT_STS_FIXED |
        {5'h0, c_r.ovf_flag, c_r.win_flag, c_r.running};
      CLEAR_WINDOW_SELECT_ISR_OFS: rd_data[1:0] = c_r.isr;
      CLEAR_WINDOW_SELECT_IMR_OFS: rd_data[1:0] = c_r.imr;
      default: rd_data = '0;
    endcase
  end

  // ****************************************************************
  // Counter, control codes, flags
  // ****************************************************************
  always_comb begin
    wr_lo = wr_en && wr_req.strb[0];
    code_wr = wr_lo && wr_req.addr == CLEAR_WINDOW_SELECT_CODE_OFS;
    clr_try = code_wr && wr_req.data[7:0] == CLEAR_WINDOW_SELECT_CODE_CLEAR && c_r.running;
    clr_ok = clr_try && win_open(c_r.win, c_r.cnt);
    clr_bad = clr_try && !win_open(c_r.win, c_r.cnt);
    dis_ok = code_wr && wr_req.data[7:0] == CLEAR_WINDOW_SELECT_CODE_DISABLE &&
             !c_r.en;
    // Clear or disable in the same cycle suppresses overflow
    ovf = c_r.running && tick && !mode_hold && c_r.cnt == 8'hFF &&
          !clr_ok && !dis_ok;
    sts_rd = rd_en && s_axi_araddr == CLEAR_WINDOW_SELECT_STS_OFS;

    c_nxt = c_r;
    c_nxt.nmi = 1'b0;
    c_nxt.crst = 1'b0;
    if (wr_lo && wr_req.addr == CLEAR_WINDOW_SELECT_CFG_OFS) begin
      c_nxt.en = wr_req.data[CLEAR_WINDOW_SELECT_CFG_EN];
      c_nxt.act = wr_req.data[CLEAR_WINDOW_SELECT_CFG_ACT];
      c_nxt.win = wr_req.data[CLEAR_WINDOW_SELECT_CFG_WIN +: 2];
      c_nxt.per = wr_req.data[CLEAR_WINDOW_SELECT_CFG_PER +: 2];
      if (wr_req.data[CLEAR_WINDOW_SELECT_CFG_EN])
        c_nxt.running = 1'b1;
    end
    if (c_r.running && tick && !mode_hold)
      c_nxt.cnt = c_r.cnt + 8'h01;
    if (clr_ok)
      c_nxt.cnt = 8'h00;
    if (dis_ok) begin
      c_nxt.running = 1'b0;
      c_nxt.cnt = 8'h00;
    end
    if (sts_rd) begin
      c_nxt.ovf_flag = 1'b0;
      c_nxt.win_flag = 1'b0;
    end
    // Clear first, so an event in the same cycle wins
    if (wr_lo && wr_req.addr == CLEAR_WINDOW_SELECT_ISR_OFS)
      c_nxt.isr = c_nxt.isr & ~wr_req.data[1:0];
    if (ovf && c_r.act)
      c_nxt.crst = 1'b1;
    if (ovf && !c_r.act) begin
      c_nxt.nmi = 1'b1;
      c_nxt.ovf_flag = 1'b1;
      c_nxt.isr[1] = 1'b1;
    end
    if (clr_bad) begin
      c_nxt.win_flag = 1'b1;
      c_nxt.isr[0] = 1'b1;
    end
    if (wr_lo && wr_req.addr == CLEAR_WINDOW_SELECT_IMR_OFS)
      c_nxt.imr = wr_req.data[1:0];
    c_nxt.irq = |(c_nxt.isr & c_nxt.imr);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      c_r <= '0;
      c_r.en <= 1'b1;
      c_r.running <= 1'b1;
      c_r.act <= CLEAR_WINDOW_SELECT_RST_ACT;
      c_r.win <= CLEAR_WINDOW_SELECT_RST_WIN;
      c_r.per <= CLEAR_WINDOW_SELECT_RST_PER;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reset_on_ovf: assert property (
    @(posedge clk) disable iff (srst)
    ovf && c_r.act |=> chip_rst_req && !nmi_req)
    else $error("overflow with reset action gave no reset request");

  a_reset_one_cycle: assert property (
    @(posedge clk) disable iff (srst)
    chip_rst_req |=> !chip_rst_req)
    else $error("reset request held longer than one cycle");

  a_clear_zeroes: assert property (
    @(posedge clk) disable iff (srst)
    clr_ok |=> c_r.cnt == 8'h00 && c_r.running)
    else $error("accepted clear did not zero the counter");

  a_disable_code: assert property (
    @(posedge clk) disable iff (srst)
    dis_ok |=> !c_r.running && c_r.cnt == 8'h00 && !c_r.en)
    else $error("disable code did not stop and clear");

  a_disable_refused: assert property (
    @(posedge clk) disable iff (srst)
    code_wr && c_r.en |=> c_r.running == $past(c_r.running))
    else $error("control code changed state while enabled");

  a_clear_beats_ovf: assert property (
    @(posedge clk) disable iff (srst)
    clr_ok && tick && c_r.cnt == 8'hFF |=> !nmi_req && !chip_rst_req)
    else $error("overflow detected despite clear");

  a_nmi_on_ovf: assert property (
    @(posedge clk) disable iff (srst)
    ovf && !c_r.act |=> nmi_req && c_r.ovf_flag && c_r.cnt == 8'h00
      ##1 !nmi_req)
    else $error("overflow interrupt not raised as one pulse");

  a_window_miss: assert property (
    @(posedge clk) disable iff (srst)
    clr_bad |=> c_r.win_flag && (c_r.cnt - $past(c_r.cnt)) <= 8'h01)
    else $error("early clear not flagged or counter cleared");

  a_read_clears: assert property (
    @(posedge clk) disable iff (srst)
    sts_rd && !ovf && !clr_bad |=> !c_r.ovf_flag && !c_r.win_flag)
    else $error("status read did not clear the flags");

  a_hold_pauses: assert property (
    @(posedge clk) disable iff (srst)
    mode_hold && !wr_en |=> $stable(c_r.cnt))
    else $error("counter moved while held");

  a_req_exclusive: assert property (
    @(posedge clk) disable iff (srst)
    !(nmi_req && chip_rst_req))
    else $error("reset and interrupt requests raised together");

  a_no_flag_reset: assert property (
    @(posedge clk) disable iff (srst)
    ovf && c_r.act && !c_r.ovf_flag |=> !c_r.ovf_flag)
    else $error("reset action overflow set the overflow flag");

  a_run_counts: assert property (
    @(posedge clk) disable iff (srst)
    c_r.running && tick && !mode_hold && !wr_en |=>
      c_r.cnt == $past(c_r.cnt) + 8'h01)
    else $error("running counter missed a source tick");

  a_stop_holds: assert property (
    @(posedge clk) disable iff (srst)
    !c_r.running |=> $stable(c_r.cnt))
    else $error("stopped counter moved");

  a_monitor_read: assert property (
    @(posedge clk) disable iff (srst)
    rd_en && s_axi_araddr == CLEAR_WINDOW_SELECT_CNT_OFS |=>
      s_axi_rdata == {24'h000000, $past(c_r.cnt)})
    else $error("counter monitor read a stale value");

  a_state_flag: assert property (
    @(posedge clk) disable iff (srst)
    sts_rd |=> s_axi_rdata[CLEAR_WINDOW_SELECT_STS_RUN] == $past(c_r.running) &&
      s_axi_rdata[7:3] == CLEAR_WINDOW_SELECT_STS_FIXED[7:3])
    else $error("status read gave a wrong state bit");

  a_ovf_beats_read: assert property (
    @(posedge clk) disable iff (srst)
    sts_rd && ovf && !c_r.act |=> c_r.ovf_flag)
    else $error("read cleared an overflow flag set with it");

  a_win_beats_read: assert property (
    @(posedge clk) disable iff (srst)
    sts_rd && clr_bad |=> c_r.win_flag)
    else $error("read cleared a window flag set with it");

  a_window_any_time: assert property (
    @(posedge clk) disable iff (srst)
    clr_try && c_r.win == 2'h0 |=> c_r.cnt == 8'h00)
    else $error("clear refused with the window always open");

  a_nmi_one_cycle: assert property (
    @(posedge clk) disable iff (srst)
    nmi_req |=> !nmi_req)
    else $error("interrupt request held longer than one cycle");

  a_bad_code_inert: assert property (
    @(posedge clk) disable iff (srst)
    code_wr && !clr_try && !dis_ok |=> c_r.en == $past(c_r.en) &&
      c_r.running == $past(c_r.running) &&
      (c_r.cnt - $past(c_r.cnt)) <= 8'h01)
    else $error("ignored control code changed the watchdog");

  a_isr_set_wins: assert property (
    @(posedge clk) disable iff (srst)
    wr_lo && wr_req.addr == CLEAR_WINDOW_SELECT_ISR_OFS && ovf && !c_r.act |=>
      c_r.isr[1])
    else $error("status clear swallowed a new overflow event");
endmodule : clear_window_select_core

// >>> logic/clear_window_select_tick_div.sv
// Source clock divider: one-cycle tick whose rate the period field picks.
// Assumes the system clock and a synchronous reset.
`timescale 1ns/100ps
module clear_window_select_tick_div import clear_window_select_pkg::*; #(
  parameter int BASE_DIV = 16,
  parameter int CW = 16
) (
  input wire logic clk, // System clock
  input wire logic srst, // Sync reset
  input wire logic [1:0] per, // Period select
  output logic tick // Source clock tick
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] lim;
  logic tick_nxt;

  // Each period step is four times the previous
  always_comb begin
    lim = CW'(BASE_DIV << (2 * per)) - CW'(1);
    tick_nxt = cnt_r >= lim;
    cnt_nxt = tick_nxt ? '0 : cnt_r + CW'(1);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule : clear_window_select_tick_div

// >>> shared/clear_window_select_pkg.sv
// Package for the windowed watchdog: register map, field layout, state.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package clear_window_select_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CLEAR_WINDOW_SELECT_CFG_OFS = 8'h00;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_CODE_OFS = 8'h04;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_CNT_OFS = 8'h08;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_STS_OFS = 8'h0C;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_ISR_OFS = 8'h10;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_IMR_OFS = 8'h14;
  localparam int CLEAR_WINDOW_SELECT_CFG_EN = 0;
  localparam int CLEAR_WINDOW_SELECT_CFG_ACT = 1;
  localparam int CLEAR_WINDOW_SELECT_CFG_WIN = 2;
  localparam int CLEAR_WINDOW_SELECT_CFG_PER = 4;
  localparam int CLEAR_WINDOW_SELECT_STS_RUN = 0;
  localparam int CLEAR_WINDOW_SELECT_STS_WIN = 1;
  localparam int CLEAR_WINDOW_SELECT_STS_OVF = 2;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_STS_FIXED = 8'h58;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CLEAR_WINDOW_SELECT_CODE_DISABLE = 8'hB1;
  localparam logic CLEAR_WINDOW_SELECT_RST_ACT = 1'b1;
  localparam logic [1:0] CLEAR_WINDOW_SELECT_RST_WIN = 2'h0;
  localparam logic [1:0] CLEAR_WINDOW_SELECT_RST_PER = 2'h3;
  localparam logic [1:0] CLEAR_WINDOW_SELECT_RESP_OK = 2'h0;
  localparam logic [1:0] CLEAR_WINDOW_SELECT_RESP_ERR = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } clear_window_select_wreq_t;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    clear_window_select_wreq_t req;
    logic wr_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } clear_window_select_axs_t;

  typedef struct packed {
    logic en;
    logic act;
    logic [1:0] win;
    logic [1:0] per;
    logic running;
    logic [7:0] cnt;
    logic ovf_flag;
    logic win_flag;
    logic [1:0] isr;
    logic [1:0] imr;
    logic irq;
    logic nmi;
    logic crst;
  } clear_window_select_core_t;

  function automatic logic clear_window_select_mapped(input logic [7:0] a);
    return a == CLEAR_WINDOW_SELECT_CFG_OFS || a == CLEAR_WINDOW_SELECT_CODE_OFS || a == CLEAR_WINDOW_SELECT_CNT_OFS ||
           a == CLEAR_WINDOW_SELECT_STS_OFS || a == CLEAR_WINDOW_SELECT_ISR_OFS || a == CLEAR_WINDOW_SELECT_IMR_OFS;
  endfunction : clear_window_select_mapped
endpackage : clear_window_select_pkg

// >>> testbench/clear_window_select_core_test.sv
// Self-checking bench for the windowed watchdog core.
// Assumes the core alone, BASE_DIV set to 1, bench acts as bus master.
`timescale 1ns/100ps
module clear_window_select_core_test import clear_window_select_pkg::*; ;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } clear_window_select_row_t;
  localparam logic [31:0] CFG_RST = {26'h0, CLEAR_WINDOW_SELECT_RST_PER, CLEAR_WINDOW_SELECT_RST_WIN,
                                     CLEAR_WINDOW_SELECT_RST_ACT, 1'b1};
  localparam logic [31:0] STS_RUN = {24'h0, CLEAR_WINDOW_SELECT_STS_FIXED} | 32'h1;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mode_hold = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic irq;
  logic nmi_req;
  logic chip_rst_req;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] c1;
  logic [31:0] c2;
  logic [31:0] c3;
  clear_window_select_row_t rows [6] = '{
    '{CLEAR_WINDOW_SELECT_CFG_OFS, CFG_RST, CLEAR_WINDOW_SELECT_RESP_OK},
    '{CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN, CLEAR_WINDOW_SELECT_RESP_OK},
    '{CLEAR_WINDOW_SELECT_ISR_OFS, 32'h0, CLEAR_WINDOW_SELECT_RESP_OK},
    '{CLEAR_WINDOW_SELECT_IMR_OFS, 32'h0, CLEAR_WINDOW_SELECT_RESP_OK},
    '{CLEAR_WINDOW_SELECT_CODE_OFS, 32'h0, CLEAR_WINDOW_SELECT_RESP_OK},
    '{8'h18, 32'h0, CLEAR_WINDOW_SELECT_RESP_ERR}};

  always #5 clk = ~clk;

  clear_window_select_core #(.BASE_DIV(1)) u_clear_window_select_core (
    .clk(clk), .srst(srst), .mode_hold(mode_hold),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .nmi_req(nmi_req),
    .chip_rst_req(chip_rst_req));

  // ****************************************************************
  // Compare and bus tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input string msg);
    cmp_count++;
    if (got !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chkb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
      end
    end
    chkb(done, "write never answered");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic done;
    done = 1'b0;
    d = 32'hX;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er}, "read response");
      end
    end
    chkb(done, "read never answered");
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, CLEAR_WINDOW_SELECT_RESP_OK);
    chk(d, exp, "register read");
  endtask : rdc

  // Reads counter, writes a code, reads again and judges the change
  task automatic try_code(input logic [7:0] code, input logic cleared);
    logic [31:0] a;
    logic [31:0] b;
    rd(CLEAR_WINDOW_SELECT_CNT_OFS, a, CLEAR_WINDOW_SELECT_RESP_OK);
    wr(CLEAR_WINDOW_SELECT_CODE_OFS, {24'h0, code}, CLEAR_WINDOW_SELECT_RESP_OK);
    rd(CLEAR_WINDOW_SELECT_CNT_OFS, b, CLEAR_WINDOW_SELECT_RESP_OK);
    chkb(cleared ? (b[7:0] < a[7:0]) : (b[7:0] > a[7:0]), "code effect");
  endtask : try_code

  task automatic wait_pulse(input logic rst_sel);
    int n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < 300 && !seen; n++) begin
      @(negedge clk);
      seen = rst_sel ? chip_rst_req : nmi_req;
    end
    chkb(seen, "overflow pulse missing");
  endtask : wait_pulse

  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Watchdog and main sequence
  // ****************************************************************
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, c1, rows[i].r);
      chk(c1, rows[i].d, "reset row");
    end
    wr(8'h18, 32'h1, CLEAR_WINDOW_SELECT_RESP_ERR);
    // Low byte strobe off: the write must be dropped
    wstrb <= 4'h0;
    wr(CLEAR_WINDOW_SELECT_CFG_OFS, 32'h00, CLEAR_WINDOW_SELECT_RESP_OK);
    wstrb <= 4'hF;
    rdc(CLEAR_WINDOW_SELECT_CFG_OFS, CFG_RST);
    wr(CLEAR_WINDOW_SELECT_CFG_OFS, 32'h01, CLEAR_WINDOW_SELECT_RESP_OK);
    wr(CLEAR_WINDOW_SELECT_IMR_OFS, 32'h03, CLEAR_WINDOW_SELECT_RESP_OK);
    wr(CLEAR_WINDOW_SELECT_CODE_OFS, {24'h0, CLEAR_WINDOW_SELECT_CODE_CLEAR}, CLEAR_WINDOW_SELECT_RESP_OK);
    repeat (40) @(posedge clk);
    try_code(CLEAR_WINDOW_SELECT_CODE_CLEAR, 1'b1);
    repeat (20) @(posedge clk);
    try_code(8'h12, 1'b0);
    try_code(CLEAR_WINDOW_SELECT_CODE_DISABLE, 1'b0);
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN);
    wait_pulse(1'b0);
    @(negedge clk);
    chkb(irq, "irq after overflow");
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN | 32'h4);
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN);
    rdc(CLEAR_WINDOW_SELECT_ISR_OFS, 32'h2);
    wr(CLEAR_WINDOW_SELECT_ISR_OFS, 32'h2, CLEAR_WINDOW_SELECT_RESP_OK);
    @(negedge clk);
    chkb(!irq, "irq after clear");
    wr(CLEAR_WINDOW_SELECT_CODE_OFS, {24'h0, CLEAR_WINDOW_SELECT_CODE_CLEAR}, CLEAR_WINDOW_SELECT_RESP_OK);
    repeat (40) @(posedge clk);
    wr(CLEAR_WINDOW_SELECT_CFG_OFS, 32'h0D, CLEAR_WINDOW_SELECT_RESP_OK);
    try_code(CLEAR_WINDOW_SELECT_CODE_CLEAR, 1'b0);
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN | 32'h2);
    @(negedge clk);
    chkb(irq, "irq after early clear");
    wr(CLEAR_WINDOW_SELECT_ISR_OFS, 32'h1, CLEAR_WINDOW_SELECT_RESP_OK);
    wr(CLEAR_WINDOW_SELECT_CFG_OFS, 32'h00, CLEAR_WINDOW_SELECT_RESP_OK);
    wr(CLEAR_WINDOW_SELECT_CODE_OFS, {24'h0, CLEAR_WINDOW_SELECT_CODE_DISABLE}, CLEAR_WINDOW_SELECT_RESP_OK);
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, {24'h0, CLEAR_WINDOW_SELECT_STS_FIXED});
    rdc(CLEAR_WINDOW_SELECT_CNT_OFS, 32'h0);
    repeat (20) @(posedge clk);
    rdc(CLEAR_WINDOW_SELECT_CNT_OFS, 32'h0);
    wr(CLEAR_WINDOW_SELECT_CFG_OFS, 32'h01, CLEAR_WINDOW_SELECT_RESP_OK);
    repeat (20) @(posedge clk);
    mode_hold <= 1'b1;
    rd(CLEAR_WINDOW_SELECT_CNT_OFS, c1, CLEAR_WINDOW_SELECT_RESP_OK);
    repeat (10) @(posedge clk);
    rd(CLEAR_WINDOW_SELECT_CNT_OFS, c2, CLEAR_WINDOW_SELECT_RESP_OK);
    chk(c2, c1, "counter paused");
    @(posedge clk);
    mode_hold <= 1'b0;
    rd(CLEAR_WINDOW_SELECT_CNT_OFS, c3, CLEAR_WINDOW_SELECT_RESP_OK);
    chkb(c3[7:0] > c1[7:0], "counter resumed");
    wr(CLEAR_WINDOW_SELECT_CFG_OFS, 32'h03, CLEAR_WINDOW_SELECT_RESP_OK);
    wait_pulse(1'b1);
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN);
    // Chip reset controller answers the request
    @(posedge clk);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdc(CLEAR_WINDOW_SELECT_CFG_OFS, CFG_RST);
    rdc(CLEAR_WINDOW_SELECT_STS_OFS, STS_RUN);
    end_of_test();
  end
endmodule : clear_window_select_core_test
